// ### hw/bas_pkg.sv
// package: register map, field layout and carrier types of the abort status block
package bas_pkg;
    // register byte offsets
    localparam logic [7:0] BAS_OFF_REMAP  = 8'h00;
    localparam logic [7:0] BAS_OFF_STATUS = 8'h04;
    localparam logic [7:0] BAS_OFF_ADDR   = 8'h08;
    localparam logic [7:0] BAS_OFF_IRQST  = 8'h0C;
    localparam logic [7:0] BAS_OFF_IRQMSK = 8'h10;
    localparam int         BAS_OFF_W      = 8;
    // abort status and remap field positions
    localparam int BAS_B_UNDEF = 0;
    localparam int BAS_B_MIS   = 1;
    localparam int BAS_B_SIZE  = 8;
    localparam int BAS_B_KIND  = 10;
    localparam int BAS_B_SRC   = 16;
    localparam int BAS_B_SAVED = 24;
    localparam int BAS_B_RMP   = 0;
    // reset values
    localparam logic [31:0] BAS_RST_WORD = 32'h0000_0000;
    localparam logic [2:0]  BAS_RST_SRC  = 3'h0;
    localparam logic [1:0]  BAS_RST_IRQ  = 2'h0;
    // access size codes
    localparam logic [1:0] BAS_SZ_BYTE = 2'h0;
    localparam logic [1:0] BAS_SZ_HALF = 2'h1;
    localparam logic [1:0] BAS_SZ_WORD = 2'h2;
    // access kind codes
    localparam logic [1:0] BAS_KD_READ  = 2'h0;
    localparam logic [1:0] BAS_KD_WRITE = 2'h1;
    localparam logic [1:0] BAS_KD_FETCH = 2'h2;
    // master source one-hot positions
    localparam int BAS_M_ETH = 0;
    localparam int BAS_M_DMA = 1;
    localparam int BAS_M_CPU = 2;
    // top-nibble region codes
    localparam logic [3:0] BAS_RG_MEM = 4'h0;
    localparam logic [3:0] BAS_RG_PER = 4'hF;
    // interrupt status bit positions
    localparam int BAS_I_UNDEF = 0;
    localparam int BAS_I_MIS   = 1;
    // ahb codes
    localparam logic [1:0] BAS_HT_NONSEQ = 2'h2;

    // bus-phase state, one-hot
    typedef enum logic [1:0] {
        BAS_PH_IDLE  = 2'b01,
        BAS_PH_WRITE = 2'b10
    } bas_phase_t;

    // one monitored master access
    typedef struct packed {
        logic        valid;   // one-cycle strobe per access
        logic [31:0] addr;    // full byte address
        logic [1:0]  size;    // byte / half / word
        logic [1:0]  kind;    // read / write / fetch
        logic [2:0]  master;  // one-hot source
    } bas_req_t;
endpackage

// ### hw/bas_abort.sv
// abort status, misalignment detector and remap toggle behind an ahb-lite slave
//
// Contract
// - misaligned word access is cancelled and aborted
// - odd half-word access is cancelled and aborted
// - check every master using size, address bits
// - processor instruction fetches never checked for alignment
// - capture full aborted address at offset 0x08
// - writing one toggles remap, zero does nothing
// - status bit 0 flags undefined address abort
// - status bit 1 flags misaligned address abort
// - bits 9:8 record aborted access size
// - bits 11:10 record aborted access kind
// - bits 18:16 show source of last abort
// - bits 26:24 saved sources, cleared by read
// - status and address registers reset to zero
// - abort indication driven to all masters
// - fourteen undefined top-nibble regions always abort
// - remap maps sram at area zero too
`timescale 1ns/10ps
module bas_abort
    import bas_pkg::*;
#(
    parameter int ADDR_W = 32   // monitored address width
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // monitored master access
    input  wire bas_req_t    req,
    // abort to every master, one cycle after the access
    output logic             abort_o,
    // sram visible at area zero
    output logic             remap_o,
    // level interrupt
    output logic             irq_o
);

    // elaboration check: fields assume a full 32-bit address
    if (ADDR_W != 32) begin : g_chk
        $error("bas_abort supports only a 32-bit address");
    end

    // elaboration check: the offset decode must reach the highest register
    if (BAS_OFF_W < 5) begin : g_chk_off
        $error("bas_abort offset decode too narrow");
    end

    // behaviour notes for the integrator:
    //  - the monitored access arrives on the same clock, one strobe per access
    //  - the abort answer comes one edge after the strobe, to all masters at once
    //  - a fetch skips only the alignment test, never the region test
    //  - size code 3 is reserved and is never treated as misaligned
    //  - hsize is not decoded; every register is one whole word
    //  - saved bits collect displaced sources not yet shown by a status read
    //  - the bus always answers with zero wait states and an okay response

    // complete state of the block
    typedef struct packed {
        bas_phase_t         ph;      // bus data-phase state
        logic [BAS_OFF_W-1:0] woff;  // latched write offset
        logic [31:0]        rdata;   // read data for data phase
        logic               remap;   // area zero shows sram
        logic               abort;   // abort pulse
        logic               undef;   // last abort undefined
        logic               mis;     // last abort misaligned
        logic [1:0]         size;    // last abort size
        logic [1:0]         kind;    // last abort kind
        logic [2:0]         src;     // last abort source
        logic [2:0]         saved;   // earlier unread sources
        logic               src_new; // shown source not yet read
        logic [31:0]        aaddr;   // last aborted address
        logic [1:0]         ist;     // sticky interrupt status
        logic [1:0]         imsk;    // interrupt mask
        logic               irq;     // interrupt level
    } bas_state_t;

    bas_state_t st_r;   // registered state
    bas_state_t st_nxt; // next state

    // assembles the abort status word from the state
    function automatic logic [31:0] status_word(input bas_state_t s);
        logic [31:0] w;
        w = BAS_RST_WORD;
        w[BAS_B_UNDEF] = s.undef;
        w[BAS_B_MIS] = s.mis;
        w[BAS_B_SIZE +: 2] = s.size;
        w[BAS_B_KIND +: 2] = s.kind;
        w[BAS_B_SRC +: 3] = s.src;
        w[BAS_B_SAVED +: 3] = s.saved;
        return w;
    endfunction

    // true when the access is not aligned to its size
    function automatic logic misaligned(input bas_req_t r);
        logic m;
        m = 1'b0;
        if (r.size == BAS_SZ_WORD) begin
            m = (r.addr[1:0] != 2'h0);
        end else if (r.size == BAS_SZ_HALF) begin
            m = r.addr[0];
        end
        // reserved size code 3 falls through as aligned
        return m;
    endfunction

    // address phase accepted for this slave
    logic        ap_ok;
    logic [BAS_OFF_W-1:0] ap_off;
    logic        chk_mis;
    logic        chk_und;
    logic        hit;
    logic        sts_rd;

    // decode of the bus address phase
    always_comb begin
        ap_ok  = hsel && hready && htrans[1];
        ap_off = haddr[BAS_OFF_W-1:0];
        sts_rd = ap_ok && !hwrite && (ap_off == BAS_OFF_STATUS);
    end

    // alignment and region checks on the monitored access
    always_comb begin
        // checked for all masters; fetches skip only alignment
        chk_mis = req.valid && (req.kind != BAS_KD_FETCH)
                  && misaligned(req);
        // top nibble neither memory nor peripheral area
        chk_und = req.valid && (req.addr[31:28] != BAS_RG_MEM)
                  && (req.addr[31:28] != BAS_RG_PER);
        hit = chk_mis || chk_und;
    end

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.abort = hit;
        // bus read data is sampled from state before this edge
        st_nxt.rdata = BAS_RST_WORD;
        if (ap_ok && !hwrite) begin
            case (ap_off)
                BAS_OFF_STATUS: st_nxt.rdata = status_word(st_r);
                BAS_OFF_ADDR:   st_nxt.rdata = st_r.aaddr;
                BAS_OFF_IRQST:  st_nxt.rdata = {30'h0, st_r.ist};
                BAS_OFF_IRQMSK: st_nxt.rdata = {30'h0, st_r.imsk};
                default:        st_nxt.rdata = BAS_RST_WORD; // write-only or unmapped
            endcase
        end
        // clear on read first, so a coinciding abort sets over it
        if (sts_rd) begin
            st_nxt.saved   = BAS_RST_SRC;
            // the read shows the current source, so it is no longer news
            st_nxt.src_new = 1'b0;
        end
        // every field of one abort lands on the same edge
        if (hit) begin
            st_nxt.undef = chk_und;
            st_nxt.mis   = chk_mis;
            st_nxt.size  = req.size;
            st_nxt.kind  = req.kind;
            st_nxt.src   = req.master;
            st_nxt.aaddr = req.addr;
            // a displaced source goes to the saved bits only if no read
            // has shown it yet; an already reported abort is not saved again
            if (st_r.src_new) begin
                st_nxt.saved = st_nxt.saved | st_r.src;
            end
            st_nxt.src_new = 1'b1;
        end
        // write data phase completes
        case (st_r.ph)
            BAS_PH_IDLE: begin
                st_nxt.ph = BAS_PH_IDLE;
            end
            BAS_PH_WRITE: begin
                st_nxt.ph = BAS_PH_IDLE;
                if (st_r.woff == BAS_OFF_REMAP && hwdata[BAS_B_RMP]) begin
                    st_nxt.remap = !st_r.remap;
                end
                if (st_r.woff == BAS_OFF_IRQMSK) begin
                    st_nxt.imsk = hwdata[1:0];
                end
            end
            default: begin
                st_nxt.ph = BAS_PH_IDLE;
            end
        endcase
        // sticky interrupt bits: w1c, a new event wins over the clear
        if (st_r.ph == BAS_PH_WRITE && st_r.woff == BAS_OFF_IRQST) begin
            st_nxt.ist = st_r.ist & ~hwdata[1:0];
        end
        st_nxt.ist[BAS_I_UNDEF] = st_nxt.ist[BAS_I_UNDEF] | chk_und;
        st_nxt.ist[BAS_I_MIS]   = st_nxt.ist[BAS_I_MIS] | chk_mis;
        st_nxt.irq = |(st_nxt.ist & st_nxt.imsk);
        // a new write address phase; back-to-back is fine at zero wait
        if (ap_ok && hwrite) begin
            st_nxt.ph   = BAS_PH_WRITE;
            st_nxt.woff = ap_off;
        end
    end

    // state register; every field resets to a constant
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r.ph    <= BAS_PH_IDLE;
            st_r.woff  <= BAS_OFF_REMAP;
            st_r.rdata <= BAS_RST_WORD;
            st_r.remap <= 1'b0;
            st_r.abort <= 1'b0;
            st_r.undef <= 1'b0;
            st_r.mis   <= 1'b0;
            st_r.size  <= BAS_SZ_BYTE;
            st_r.kind  <= BAS_KD_READ;
            st_r.src   <= BAS_RST_SRC;
            st_r.saved <= BAS_RST_SRC;
            st_r.src_new <= 1'b0;
            st_r.aaddr <= BAS_RST_WORD;
            st_r.ist   <= BAS_RST_IRQ;
            st_r.imsk  <= BAS_RST_IRQ;
            st_r.irq   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state flops; zero wait, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_r.rdata;
    assign abort_o   = st_r.abort;
    assign remap_o   = st_r.remap;
    assign irq_o     = st_r.irq;

    // assertions: each one watches outputs or state the block drives
    // write of a one to the remap register: address then data phase
    sequence s_remap_wr;
        (hsel && hready && htrans[1] && hwrite && haddr[BAS_OFF_W-1:0] == BAS_OFF_REMAP)
        ##1 hwdata[BAS_B_RMP];
    endsequence

    // status read in the same cycle as an abort
    sequence s_rd_and_abort;
        sts_rd && hit;
    endsequence

    // word access off a four-byte boundary must abort
    a_word_misalign: assert property (@(posedge hclk) disable iff (!hresetn)
        req.valid && req.size == BAS_SZ_WORD && req.addr[1:0] != 2'h0
        && req.kind != BAS_KD_FETCH |=> abort_o && st_r.mis)
        else $error("misaligned word not aborted");

    // half-word access at an odd address must abort
    a_half_misalign: assert property (@(posedge hclk) disable iff (!hresetn)
        req.valid && req.size == BAS_SZ_HALF && req.addr[0]
        && req.kind != BAS_KD_FETCH |=> abort_o && st_r.size == BAS_SZ_HALF)
        else $error("odd half-word not aborted");

    // fetch inside internal memory is never aborted
    a_fetch_exempt: assert property (@(posedge hclk) disable iff (!hresetn)
        req.valid && req.kind == BAS_KD_FETCH && req.addr[31:28] == BAS_RG_MEM
        |=> !abort_o)
        else $error("fetch aborted for alignment");

    // any access to an undefined region must abort
    a_undef_region: assert property (@(posedge hclk) disable iff (!hresetn)
        req.valid && req.addr[31:28] != BAS_RG_MEM && req.addr[31:28] != BAS_RG_PER
        |=> abort_o && st_r.undef)
        else $error("undefined region not aborted");

    // address and kind of the aborted access are kept
    a_addr_capture: assert property (@(posedge hclk) disable iff (!hresetn)
        abort_o |-> st_r.aaddr == $past(req.addr) && st_r.kind == $past(req.kind))
        else $error("aborted address not captured");

    // source bits name the master of the last abort
    a_src_last: assert property (@(posedge hclk) disable iff (!hresetn)
        abort_o |-> st_r.src == $past(req.master))
        else $error("abort source wrong");

    // a one written to the remap register flips remap
    a_remap_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
        s_remap_wr |=> remap_o != $past(remap_o))
        else $error("remap did not toggle");

    // remap moves only at the data phase of a write
    a_remap_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        st_r.ph != BAS_PH_WRITE |=> $stable(remap_o))
        else $error("remap changed without write");

    // a read beside an abort must not lose the displaced unread source
    a_saved_survive: assert property (@(posedge hclk) disable iff (!hresetn)
        s_rd_and_abort ##0 st_r.src_new |=> st_r.saved == $past(st_r.src))
        else $error("saved source lost on read");

    // interrupt follows the masked sticky status
    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_o == |(st_r.ist & st_r.imsk))
        else $error("interrupt level wrong");

    // access in a defined region that keeps its alignment
    sequence s_clean_access;
        req.valid && (req.addr[31:28] == BAS_RG_MEM || req.addr[31:28] == BAS_RG_PER)
        && (req.kind == BAS_KD_FETCH || req.size == BAS_SZ_BYTE
            || (req.size == BAS_SZ_WORD && req.addr[1:0] == 2'h0)
            || (req.size == BAS_SZ_HALF && !req.addr[0]));
    endsequence

    // a clean access must never be aborted
    a_no_false_abort: assert property (@(posedge hclk) disable iff (!hresetn)
        s_clean_access |=> !abort_o)
        else $error("clean access aborted");

    // no abort pulse without an access behind it
    a_abort_only_req: assert property (@(posedge hclk) disable iff (!hresetn)
        !req.valid |=> !abort_o)
        else $error("abort without access");

    // status and captured address read zero while reset holds
    a_reset_zero: assert property (@(posedge hclk)
        !hresetn ##1 !hresetn |-> status_word(st_r) == BAS_RST_WORD
        && st_r.aaddr == BAS_RST_WORD)
        else $error("abort registers not zero in reset");

    // a status read alone clears the saved sources
    a_saved_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        sts_rd && !hit |=> st_r.saved == BAS_RST_SRC)
        else $error("saved sources not cleared by read");

    // size lands with the pulse and the new source is marked unread
    a_fields_together: assert property (@(posedge hclk) disable iff (!hresetn)
        abort_o |-> st_r.size == $past(req.size) && st_r.src_new)
        else $error("abort fields not updated together");

    // every abort leaves a sticky interrupt cause behind
    a_irq_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        hit |=> st_r.ist != BAS_RST_IRQ)
        else $error("abort left no interrupt cause");

    // read data returns to zero outside a read data phase
    a_rdata_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        !(ap_ok && !hwrite) |=> hrdata == BAS_RST_WORD)
        else $error("read data not idle");

endmodule

// ### verif/bas_master_model.sv
// bus-master model: turns one bench command into one monitored access strobe
`timescale 1ns/10ps
module bas_master_model
    import bas_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        go,      // one-cycle command from the bench
    input  wire logic [31:0] addr,    // byte address of the access
    input  wire logic [1:0]  size,    // byte / half / word
    input  wire logic [1:0]  kind,    // read / write / fetch
    input  wire logic [2:0]  master,  // one-hot issuing master
    output bas_req_t         req      // strobe seen by the abort block
);
    // one strobe per command; idle fields flip so stale values never pass as fresh
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
        end else if (go) begin
            req <= '{1'b1, addr, size, kind, master};
        end else begin
            req <= '{1'b0, ~req.addr, ~req.size, ~req.kind, ~req.master};
        end
    end
endmodule

// ### verif/tb_top.sv
// self-checking bench of the abort status block: corners, random traffic, remap, irq
`timescale 1ns/10ps
module tb_top;
    import bas_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = '0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic        hreadyout, hresp, abort_o, remap_o, irq_o, go = 1'b0;
    logic [31:0] hrdata, m_a = '0, e_ad = '0;
    logic [1:0]  m_s = '0, m_k = '0, e_sz = '0, e_kd = '0, e_irq = '0, e_msk = '0;
    logic [2:0]  m_m = '0, e_src = '0, e_sav = '0;
    logic        e_und = 1'b0, e_mis = 1'b0, e_frs = 1'b0;
    bas_req_t    req;
    int          failures = 0, checks_done = 0;

    // 50 mhz clock
    always #10 hclk = ~hclk;

    bas_master_model u_mst (.hclk(hclk), .hresetn(hresetn), .go(go), .addr(m_a), .size(m_s),
        .kind(m_k), .master(m_m), .req(req));
    // single slave, so its ready is the bus ready; word transfers only
    bas_abort u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req(req), .abort_o(abort_o),
        .remap_o(remap_o), .irq_o(irq_o));

    // expected abort status word built from the bench's own state
    function automatic logic [31:0] stat();
        return {5'h0, e_sav, 5'h0, e_src, 4'h0, e_kd, e_sz, 6'h0, e_mis, e_und};
    endfunction

    // pseudo-random source, one shift per call
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // bounded wait for the bus ready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            failures++;
            final_report();
        end
    endtask

    // one single word transfer: address phase held until ready, then data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= BAS_HT_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
        chk(hresp, 1'b0, "okay response");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r, exp, what);
    endtask

    // status read clears the saved sources, then the captured address
    task automatic rd_st;
        rd_chk(BAS_OFF_STATUS, stat(), "status");
        e_sav = 3'h0;
        e_frs = 1'b0;
        rd_chk(BAS_OFF_ADDR, e_ad, "address");
    endtask

    // one monitored access, abort expected one cycle after it is taken
    task automatic acc(input logic [31:0] a, input logic [1:0] s, k, input logic [2:0] m);
        logic und, mis;
        und = a[31:28] != BAS_RG_MEM && a[31:28] != BAS_RG_PER;
        mis = k != BAS_KD_FETCH && ((s == BAS_SZ_WORD && a[1:0] != 2'h0)
              || (s == BAS_SZ_HALF && a[0]));
        @(posedge hclk);
        go <= 1'b1;
        m_a <= a;
        m_s <= s;
        m_k <= k;
        m_m <= m;
        @(posedge hclk);
        go <= 1'b0;
        @(posedge hclk);
        #1;
        if (und || mis) begin
            e_sav = e_sav | (e_frs ? e_src : 3'h0);
            {e_src, e_und, e_mis, e_sz, e_kd, e_ad} = {m, und, mis, s, k, a};
            e_frs = 1'b1;
            e_irq = e_irq | {mis, und};
        end
        chk(abort_o, und || mis, "abort");
        chk(irq_o, |(e_irq & e_msk), "irq level");
        @(posedge hclk);
        #1;
        chk(abort_o, 1'b0, "abort pulse");
    endtask

    task automatic one(input logic [31:0] a, input logic [1:0] s, k, input logic [2:0] m);
        acc(a, s, k, m);
        rd_st();
    endtask

    initial begin
        logic [31:0] r, x, lf;
        logic [3:0]  tp;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd_st();
        rd_chk(8'h20, 32'h0, "unmapped");
        $display("test reset finished");
        one(32'h0000_0002, BAS_SZ_WORD, BAS_KD_READ, 3'h4);
        one(32'h0020_0001, BAS_SZ_HALF, BAS_KD_WRITE, 3'h2);
        one(32'hF000_0003, BAS_SZ_BYTE, BAS_KD_WRITE, 3'h1);
        one(32'h0000_0001, BAS_SZ_WORD, BAS_KD_FETCH, 3'h4);
        one(32'h1000_0000, BAS_SZ_WORD, BAS_KD_FETCH, 3'h4);
        one(32'hE000_0001, BAS_SZ_HALF, BAS_KD_READ, 3'h1);
        one(32'h7000_0003, BAS_SZ_BYTE, BAS_KD_READ, 3'h2);
        // three aborts before one read: the first two pile up in the saved sources
        acc(32'h5000_0000, BAS_SZ_BYTE, BAS_KD_READ, 3'h1);
        acc(32'h0000_0003, BAS_SZ_HALF, BAS_KD_READ, 3'h4);
        one(32'h6000_0004, BAS_SZ_WORD, BAS_KD_WRITE, 3'h2);
        // status read taken at the very edge of a new abort
        acc(32'h2000_0000, BAS_SZ_BYTE, BAS_KD_WRITE, 3'h2);
        x = stat();
        e_sav = 3'h0;
        fork
            acc(32'h3000_0000, BAS_SZ_WORD, BAS_KD_READ, 3'h1);
            begin
                @(posedge hclk);
                ahb(1'b0, BAS_OFF_STATUS, 32'h0, r);
            end
        join
        chk(r, x, "read beside abort");
        rd_st();
        $display("test corners finished");
        // random traffic, top nibble biased toward the defined regions
        lf = 32'h0000_0046;
        for (int i = 0; i < 40; i++) begin
            lf = lfsr(lf);
            x = lf;
            lf = lfsr(lfsr(lfsr(lf)));
            tp = lf[1:0] == 2'h0 ? BAS_RG_MEM : lf[1:0] == 2'h1 ? BAS_RG_PER : x[31:28];
            one({tp, x[27:0]}, lf[3:2] == 2'h3 ? BAS_SZ_WORD : lf[3:2],
                lf[5:4] == 2'h3 ? BAS_KD_FETCH : lf[5:4], 3'h1 << (lf[7:6] % 3));
        end
        $display("test random finished");
        // remap toggles on a one, ignores a zero, reads back as zero
        wr(BAS_OFF_REMAP, 32'h1);
        chk(remap_o, 1'b1, "remap on");
        wr(BAS_OFF_REMAP, 32'hFFFF_FFFE);
        chk(remap_o, 1'b1, "remap kept");
        wr(BAS_OFF_REMAP, 32'h1);
        chk(remap_o, 1'b0, "remap off");
        rd_chk(BAS_OFF_REMAP, 32'h0, "remap read");
        $display("test remap finished");
        // interrupt: unmask, raise, clear, then mask the misaligned cause
        e_msk = 2'h3;
        wr(BAS_OFF_IRQMSK, 32'h3);
        rd_chk(BAS_OFF_IRQMSK, 32'h3, "mask");
        rd_chk(BAS_OFF_IRQST, {30'h0, e_irq}, "irq status");
        @(posedge hclk);
        #1;
        chk(irq_o, |(e_irq & e_msk), "irq raised");
        wr(BAS_OFF_IRQST, 32'h3);
        e_irq = 2'h0;
        @(posedge hclk);
        #1;
        chk(irq_o, 1'b0, "irq cleared");
        e_msk = 2'h1;
        wr(BAS_OFF_IRQMSK, 32'h1);
        acc(32'h0000_0002, BAS_SZ_WORD, BAS_KD_WRITE, 3'h2);
        acc(32'h4000_0000, BAS_SZ_WORD, BAS_KD_WRITE, 3'h1);
        rd_chk(BAS_OFF_IRQST, 32'h3, "irq both");
        $display("test irq finished");
        final_report();
    end
endmodule
